/* File: rtl/hioc_pkg.sv */
package hioc_pkg;
   // register offsets (byte addresses from base)
   localparam logic [7:0] OFS_CHIP_IDENTITY = 8'h50;
   localparam logic [7:0] OFS_IRQ_OUTPUT_CONFIG = 8'h54;
   localparam logic [7:0] OFS_INTERRUPT_STATUS = 8'h58;
   localparam logic [7:0] OFS_INTERRUPT_ENABLE_MASK = 8'h5c;
   // output configuration field positions
   localparam int HOLDOFF_INTERVAL_LSB = 24;
   localparam int HOLDOFF_RESTART_BIT = 14;
   localparam int HOLDOFF_ACTIVE_BIT = 13;
   localparam int COMBINED_REQ_BIT = 12;
   localparam int OUTPUT_GATE_BIT = 8;
   localparam int OUTPUT_POLARITY_BIT = 4;
   localparam int DRIVER_TYPE_BIT = 0;
   // power event source position in the status register
   localparam int POWER_EVENT_BIT = 17;
   // reset values
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   // timing: tick of 10 us at 20 MHz
   localparam int CLK_HZ = 20000000;
   localparam int TICK_NS = 10000;
   localparam int CLK_NS = 1000000000 / CLK_HZ;
   localparam int TICK_CYCLES = TICK_NS / CLK_NS;
   localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
   // host bus request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [31:0] wdata;
   } hioc_bus_s;
endpackage

/* File: rtl/hioc_top.sv */
////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// [R1] hold-off interval bits 31:24, 10 us units
// [R2] zero interval disables hold-off, delivers pending
// [R3] new non-zero interval applies to later requests
// [R4] power event bypasses hold-off interval
// [R5] bit 14 restarts interval, self-clears
// [R6] bit 13 shows hold-off, withholds pin
// [R7] bit 12 shows combined request always
// [R8] bit 8 clear keeps pin deasserted
// [R9] bit 4 polarity, ignored in open-drain
// [R10] bit 0 driver type, open-drain active low
// [R11] polarity and driver survive software reset
// [R12] identity register: id high, revision low
// [R13] config 54h, status 58h, enable 5Ch
// [R14] write one clears status bit
// [R15] combined request is OR of status AND enable
// [R16] hold-off starts at pin deassert, prescaled tick
module hioc_top #(
   parameter logic [15:0] DESIGN_ID = 16'h0001, // arbitrary value
   parameter logic [15:0] REVISION = 16'h0000, // arbitrary value
   parameter int TICK_DIV = hioc_pkg::TICK_CYCLES
) (
   // clock and resets
   input wire logic clk,
   input wire logic rst,
   input wire logic soft_rst,
   // host register access
   input wire hioc_pkg::hioc_bus_s bus,
   output logic [31:0] rdata,
   // interrupt sources, one-cycle event pulses
   input wire logic [31:0] irq_event,
   // request pin
   output logic irq_o,
   output logic irq_oe_n
);
   import hioc_pkg::*;

   logic [31:0] status_reg;
   logic [31:0] enable_reg;
   logic [7:0] interval_reg;
   logic gate_reg;
   logic polarity_reg;
   logic driver_reg;
   logic restart_reg;
   logic [7:0] hold_cnt_reg;
   logic [15:0] pre_reg;
   logic active_reg;
   logic pin_on_reg;
   logic pin_on_next;
   logic combined;
   logic pwr_req;
   logic wr_cfg;
   logic sreset;

   assign sreset = rst | soft_rst;
   assign wr_cfg = bus.wr && bus.addr == OFS_IRQ_OUTPUT_CONFIG; // R13

   ////////////////////////////////////////////////////////////////////////
   // status: set wins over write-one clear
   always_ff @(posedge clk) begin
      if (sreset) begin
         status_reg <= RST_ZERO;
      end else if (bus.wr && bus.addr == OFS_INTERRUPT_STATUS) begin
         status_reg <= (status_reg & ~bus.wdata) | irq_event; // R14
      end else begin
         status_reg <= status_reg | irq_event;
      end
   end

   // enable mask
   always_ff @(posedge clk) begin
      if (sreset) begin
         enable_reg <= RST_ZERO;
      end else if (bus.wr && bus.addr == OFS_INTERRUPT_ENABLE_MASK) begin
         enable_reg <= bus.wdata;
      end
   end

   // combined request and power event bypass
   assign combined = |(status_reg & enable_reg); // R15 R7
   assign pwr_req = status_reg[POWER_EVENT_BIT] &
      enable_reg[POWER_EVENT_BIT]; // R4

   ////////////////////////////////////////////////////////////////////////
   // software-resettable config fields
   always_ff @(posedge clk) begin
      if (sreset) begin
         interval_reg <= '0;
         gate_reg <= 1'b0;
         restart_reg <= 1'b0;
      end else begin
         restart_reg <= wr_cfg && bus.wdata[HOLDOFF_RESTART_BIT]; // R5
         if (wr_cfg) begin
            interval_reg <= bus.wdata[HOLDOFF_INTERVAL_LSB +: 8]; // R1 R3
            gate_reg <= bus.wdata[OUTPUT_GATE_BIT];
         end
      end
   end

   // pin style bits, hardware reset only
   always_ff @(posedge clk) begin
      if (rst) begin
         polarity_reg <= 1'b0;
         driver_reg <= 1'b0;
      end else if (wr_cfg) begin
         polarity_reg <= bus.wdata[OUTPUT_POLARITY_BIT]; // R11 R9
         driver_reg <= bus.wdata[DRIVER_TYPE_BIT]; // R11 R10
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // 10 us prescaler, held clear outside hold-off and cleared on restart
   always_ff @(posedge clk) begin
      if (sreset || !active_reg || restart_reg) begin
         pre_reg <= '0;
      end else if (pre_reg == 16'(TICK_DIV - 1)) begin
         pre_reg <= '0; // R16
      end else begin
         pre_reg <= pre_reg + 16'd1;
      end
   end

   // hold-off interval counter
   always_ff @(posedge clk) begin
      if (sreset || interval_reg == 8'd0) begin
         active_reg <= 1'b0; // R2
         hold_cnt_reg <= '0;
      end else if (restart_reg || (pin_on_reg && !pin_on_next)) begin
         active_reg <= 1'b1; // R5 R16
         hold_cnt_reg <= interval_reg; // R3
      end else if (active_reg && pre_reg == 16'(TICK_DIV - 1)) begin
         if (hold_cnt_reg <= 8'd1) begin
            active_reg <= 1'b0;
            hold_cnt_reg <= '0;
         end else begin
            hold_cnt_reg <= hold_cnt_reg - 8'd1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin assertion: gated, withheld during hold-off except power event
   always_comb begin
      pin_on_next = gate_reg && ((combined && !active_reg) || pwr_req);
      // R8 R6 R4
   end

   always_ff @(posedge clk) begin
      if (sreset) begin
         pin_on_reg <= 1'b0;
      end else begin
         pin_on_reg <= pin_on_next;
      end
   end

   // driver: oe low while driving
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_o <= 1'b1;
         irq_oe_n <= 1'b1;
      end else if (!driver_reg) begin
         irq_o <= 1'b0; // R10
         irq_oe_n <= !pin_on_next;
      end else begin
         irq_o <= pin_on_next ~^ polarity_reg; // R9
         irq_oe_n <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register read, one cycle after request
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= RST_ZERO;
      end else if (!bus.rd) begin
         rdata <= RST_ZERO;
      end else begin
         case (bus.addr)
            OFS_CHIP_IDENTITY: rdata <= {DESIGN_ID, REVISION}; // R12
            OFS_IRQ_OUTPUT_CONFIG: begin
               rdata <= RST_ZERO;
               rdata[HOLDOFF_INTERVAL_LSB +: 8] <= interval_reg;
               rdata[HOLDOFF_ACTIVE_BIT] <= active_reg; // R6
               rdata[COMBINED_REQ_BIT] <= combined; // R7
               rdata[OUTPUT_GATE_BIT] <= gate_reg;
               rdata[OUTPUT_POLARITY_BIT] <= polarity_reg;
               rdata[DRIVER_TYPE_BIT] <= driver_reg;
            end
            OFS_INTERRUPT_STATUS: rdata <= status_reg;
            OFS_INTERRUPT_ENABLE_MASK: rdata <= enable_reg;
            default: rdata <= RST_ZERO;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_gate_off;
      @(posedge clk) disable iff (rst)
         !gate_reg |=> irq_oe_n || irq_o != $past(polarity_reg);
   endproperty
   a_gate_off: assert property (p_gate_off) else $error("pin asserted while gated"); // R8

   property p_od_low;
      @(posedge clk) disable iff (rst)
         !rst && !driver_reg && $stable(driver_reg) |=> irq_o == 1'b0;
   endproperty
   a_od_low: assert property (p_od_low) else $error("open-drain drove high"); // R10

   property p_comb;
      @(posedge clk) disable iff (rst)
         bus.rd && bus.addr == OFS_IRQ_OUTPUT_CONFIG |=>
         rdata[COMBINED_REQ_BIT] ==
         (|($past(status_reg) & $past(enable_reg)));
   endproperty
   a_comb: assert property (p_comb) else $error("combined request wrong"); // R15

   property p_zero_int;
      @(posedge clk) disable iff (rst)
         interval_reg == 8'd0 |=> !active_reg;
   endproperty
   a_zero_int: assert property (p_zero_int) else $error("hold-off with zero"); // R2

   property p_withhold;
      @(posedge clk) disable iff (rst)
         active_reg && !pwr_req |=>
         irq_oe_n || irq_o != $past(polarity_reg);
   endproperty
   a_withhold: assert property (p_withhold) else $error("pin during hold-off"); // R6

   property p_pwr;
      @(posedge clk) disable iff (rst)
         pwr_req && gate_reg && driver_reg && !rst |=>
         !irq_oe_n && irq_o == $past(polarity_reg);
   endproperty
   a_pwr: assert property (p_pwr) else $error("power event delayed"); // R4

   property p_restart;
      @(posedge clk) disable iff (rst || soft_rst)
         wr_cfg && bus.wdata[HOLDOFF_RESTART_BIT] && bus.wdata[31:24] != 8'd0
         |=> ##1 active_reg && !restart_reg;
   endproperty
   a_restart: assert property (p_restart) else $error("restart missed"); // R5

   property p_w1c;
      @(posedge clk) disable iff (rst || soft_rst)
         bus.wr && bus.addr == OFS_INTERRUPT_STATUS && bus.wdata[0] &&
         !irq_event[0] |=> !status_reg[0];
   endproperty
   a_w1c: assert property (p_w1c) else $error("status not cleared"); // R14

   property p_survive;
      @(posedge clk) disable iff (rst)
         soft_rst && !wr_cfg |=> $stable(driver_reg) && $stable(polarity_reg);
   endproperty
   a_survive: assert property (p_survive) else $error("style bits lost"); // R11
endmodule

/* File: tb/hioc_host.sv */
module hioc_host (
   // clock
   input wire logic clk,
   // register bus
   output hioc_pkg::hioc_bus_s bus,
   input wire logic [31:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   import hioc_pkg::*;
   initial begin
      bus = '0;
   end
   // one write strobe, dropped after its taking edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   // one read strobe, data taken in the cycle after
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: ~bus.wdata};
      @(posedge clk);
      bus.rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
   // acknowledge by writing ones to status bits
   task automatic ack(input logic [31:0] m);
      wr(OFS_INTERRUPT_STATUS, m);
   endtask
endmodule

/* File: tb/host_irq_output_control_tb.sv */
module host_irq_output_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import hioc_pkg::*;
   localparam int DIV = 4;
   localparam logic [31:0] IDENT = 32'h0a5c_0003; // arbitrary value
   logic clk = 0, rst = 1, soft_rst = 0;
   logic [31:0] irq_event = '0, rdata, v;
   logic irq_o, irq_oe_n;
   hioc_bus_s bus;
   int fails = 0, n_compared = 0, n;
   logic [31:0] m_sts, m_en, r;
   logic [7:0] ofs[4] = '{8'h54, 8'h58, 8'h5c, 8'h60};
   // clock
   initial forever #25 clk = ~clk;
   hioc_host host (.clk(clk), .bus(bus), .rdata(rdata));
   hioc_top #(.DESIGN_ID(IDENT[31:16]), .REVISION(IDENT[15:0]),
      .TICK_DIV(DIV)) dut (.clk(clk), .rst(rst), .soft_rst(soft_rst),
      .bus(bus), .rdata(rdata), .irq_event(irq_event), .irq_o(irq_o),
      .irq_oe_n(irq_oe_n));
   ////////////////////////////////////////////////////////////////////////
   // verdict and comparisons
   task automatic summarize;
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic cmp_reg(input logic [7:0] a, input logic [31:0] e);
      host.rd(a, v);
      cmp(v, e);
   endtask
   // pin value is a don't-care while released
   task automatic cmp_pin(input logic [1:0] e);
      cmp(32'({irq_o | e[0], irq_oe_n}), 32'(e));
   endtask
   // withheld span must sit near interval times prescale
   task automatic cmp_span(input int k);
      cmp(32'(n >= k * DIV - 2 && n <= k * DIV + 3), 32'h0000_0001);
   endtask
   task automatic pulse(input logic [31:0] m);
      @(posedge clk);
      irq_event <= m;
      @(posedge clk);
      irq_event <= '0;
   endtask
   task automatic wait_pin;
      n = 0;
      while (irq_o !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
   endtask
   // assert, acknowledge, re-raise, then time the hold-off
   task automatic span(input int k, input logic [31:0] c);
      host.wr(OFS_IRQ_OUTPUT_CONFIG, 32'(k) << 24 | c);
      pulse(32'h0000_0008);
      wait_pin();
      host.ack(32'h0000_0008);
      pulse(32'h0000_0008);
      wait_pin();
   endtask
   ////////////////////////////////////////////////////////////////////////
   // watchdog
   initial begin
      #(50 * 20000);
      fails++;
      summarize();
   end
   ////////////////////////////////////////////////////////////////////////
   // tests
   initial begin
      r = $urandom(71);
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      cmp_reg(OFS_CHIP_IDENTITY, IDENT);
      foreach (ofs[i]) cmp_reg(ofs[i], RST_ZERO);
      cmp_pin(2'b11);
      m_en = $urandom;
      host.wr(OFS_INTERRUPT_ENABLE_MASK, m_en);
      cmp_reg(OFS_INTERRUPT_ENABLE_MASK, m_en);
      host.wr(OFS_CHIP_IDENTITY, ~IDENT);
      cmp_reg(OFS_CHIP_IDENTITY, IDENT);
      m_sts = $urandom;
      pulse(m_sts);
      for (int i = 0; i < 2; i++) begin
         cmp_reg(OFS_INTERRUPT_STATUS, m_sts);
         cmp_reg(OFS_IRQ_OUTPUT_CONFIG, 32'(|(m_sts & m_en)) << 12);
         r = (i == 0) ? $urandom : 32'hffff_ffff;
         host.ack(r);
         m_sts = m_sts & ~r;
      end
      host.wr(OFS_INTERRUPT_ENABLE_MASK, 32'h0002_0008);
      host.wr(OFS_IRQ_OUTPUT_CONFIG, 32'h0000_0110);
      pulse(32'h0000_0008);
      repeat (2) @(posedge clk);
      cmp_pin(2'b00);
      host.wr(OFS_IRQ_OUTPUT_CONFIG, 32'h0000_0010);
      repeat (2) @(posedge clk);
      cmp_pin(2'b11);
      cmp_reg(OFS_IRQ_OUTPUT_CONFIG, 32'h0000_1010);
      for (int p = 0; p < 2; p++) begin
         host.wr(OFS_IRQ_OUTPUT_CONFIG, 32'h0000_0101 | 32'(p) << 4);
         repeat (2) @(posedge clk);
         cmp_pin({p[0], 1'b0});
      end
      @(posedge clk);
      soft_rst <= 1'b1;
      @(posedge clk);
      soft_rst <= 1'b0;
      cmp_reg(OFS_IRQ_OUTPUT_CONFIG, 32'h0000_0011);
      cmp_reg(OFS_INTERRUPT_ENABLE_MASK, RST_ZERO);
      cmp_pin(2'b00);
      host.wr(OFS_INTERRUPT_ENABLE_MASK, 32'h0002_0008);
      span(2, 32'h0000_0111);
      cmp_span(2);
      span(5, 32'h0000_0111);
      cmp_span(5);
      host.ack(32'h0000_0008);
      cmp_reg(OFS_IRQ_OUTPUT_CONFIG, 32'h0500_2111);
      pulse(32'h0002_0000);
      repeat (2) @(posedge clk);
      cmp_pin(2'b10);
      host.ack(32'h0002_0000);
      repeat (5 * DIV - 4) @(posedge clk);
      host.wr(OFS_IRQ_OUTPUT_CONFIG, 32'h0500_4111);
      pulse(32'h0000_0008);
      wait_pin();
      cmp_span(5);
      cmp_reg(OFS_IRQ_OUTPUT_CONFIG, 32'h0500_1111);
      host.ack(32'h0000_0008);
      pulse(32'h0000_0008);
      host.wr(OFS_IRQ_OUTPUT_CONFIG, 32'h0000_0111);
      repeat (3) @(posedge clk);
      cmp_pin(2'b10);
      summarize();
   end
endmodule
